// ---- design/muting_pkg.sv ----
// Constants, register map and carrier types of the muting supervisor.
//
// Notes on behaviour
// - Without light path end or exit monitoring, muting ends when the last sensor pair goes inactive.
// - With light path end, muting ends when the light path is clear again.
// - An optional end delay, at most 1000 ms, follows the light path clearing.
// - With light path end but no exit monitoring, muting still ends when the muting condition is lost.
// - Exit monitoring starts the hold timer when the muting condition is lost.
// - Exit monitoring ends on hold expiry, or on path clear with light path end.
// - Direction detection needs four sensors and enforces pair A or pair B first.
// - Direction detection ignores sensor order inside a pair.
// - Fixed sequence accepts only forward order or only its reverse, as set.
// - Changing sequence accepts forward or reverse; two sensors disable it.
// - A sequence error is raised only while muting, when sensors do not trigger and clear in order.
// - Enabling the auxiliary dynamic input forces direction detection on.
// - Partial blanking masks only the set beam range while muting is valid.
// - Any interrupted beam outside the blanked range switches outputs off.
// - The blanked range is a start side plus a beam count.
// - Override mutes the beams that partial blanking keeps active.
// - The total muting time limit also runs during partial blanking.
// - The muting lamp stays dark when only partial blanking is active.
// - Total limit is 10 to 300 s, or up to 8 h with exit monitoring.
package muting_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int MS_PER_S      = 1000;
  localparam logic [15:0] END_DELAY_MAX_MS = 16'h03E8;
  localparam logic [15:0] TOTAL_MIN_S      = 16'h000A;
  localparam logic [15:0] TOTAL_MAX_S      = 16'h012C;
  localparam logic [15:0] TOTAL_MAX_EXIT_S = 16'h7080;

  // ----------------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DELAY  = 8'h04;
  localparam logic [7:0] OFS_HOLD   = 8'h08;
  localparam logic [7:0] OFS_TOTAL  = 8'h0C;
  localparam logic [7:0] OFS_BLANK  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] HOLD_RESET = 16'h01F4;
  localparam logic [15:0] TOTAL_RESET = 16'h003C;
  localparam int STATUS_ERR_BIT = 0;
  localparam int BLANK_CNT_LSB  = 8;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [5:0] spare;
    logic       partial_blank_en;
    logic       aux_dynamic_en;
    logic       seq_changing;
    logic       seq_en;
    logic       dir_b_first;
    logic       dir_en;
    logic       four_sensors;
    logic       total_en;
    logic       exit_mon;
    logic       light_path_end_option;
  } ctrl_t;

  typedef struct packed {
    logic second_pair_sensor_two;
    logic second_pair_sensor_one;
    logic first_pair_sensor_two;
    logic first_pair_sensor_one;
  } sensors_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_MUTED = 5'h02,
    ST_HOLD  = 5'h04,
    ST_DELAY = 5'h08,
    ST_CLEAR = 5'h10
  } mute_state_t;

endpackage

// ---- design/muting_end_sequence_blanking.sv ----
// Muting supervisor: end of muting, exit hold, direction, sequence and partial blanking.
`timescale 1ns/1ps
`default_nettype none
module muting_end_sequence_blanking #(
  parameter int BEAMS     = 16,
  parameter int MS_CYCLES = muting_pkg::MS_CYCLES
) (
  input  wire logic                      CORE_CLK,
  input  wire logic                      RST,
  input  wire logic [7:0]                AVS_ADDRESS,
  input  wire logic                      AVS_READ,
  input  wire logic                      AVS_WRITE,
  input  wire logic [31:0]               AVS_WRITEDATA,
  output var  logic [31:0]               AVS_READDATA,
  output var  logic                      AVS_WAITREQUEST,
  input  wire muting_pkg::sensors_t      MUTING_SENSORS,
  input  wire logic                      AUXILIARY_DYNAMIC_INPUT,
  input  wire logic                      OVERRIDE_ACTIVE,
  input  wire logic [BEAMS-1:0]          BEAM_INTERRUPTED,
  output var  logic                      SAFETY_SWITCH_OUTPUT,
  output var  logic                      MUTING_LAMP,
  output var  logic                      MUTING_ACTIVE,
  output var  logic                      MUTING_ERROR
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  generate
    if (BEAMS < 2 || BEAMS > 255) begin : g_bad_beams
      $error("BEAMS must lie between 2 and 255");
    end
    if (MS_CYCLES < 2) begin : g_bad_ms
      $error("MS_CYCLES must be at least 2");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [BEAMS-1:0] blank_mask(input logic remote,
                                                  input logic [7:0] cnt);
    logic [BEAMS-1:0] m;
    m = '0;
    for (int i = 0; i < BEAMS; i++) begin
      if (remote) begin
        m[i] = (BEAMS - i) <= int'(cnt);
      end else begin
        m[i] = i < int'(cnt);
      end
    end
    return m;
  endfunction

  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  function automatic logic [1:0] seq_index(input logic reverse, input logic [1:0] k);
    logic [1:0] r;
    r = reverse ? 2'h3 - k : k;
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0]       sens_meta;
  logic [3:0]       sens;
  logic [3:0]       sens_prev;
  logic [BEAMS-1:0] beam_meta;
  logic [BEAMS-1:0] beam;
  logic [1:0]       misc_meta;
  logic [1:0]       misc;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sens_meta <= '0;
      sens      <= '0;
      sens_prev <= '0;
      beam_meta <= '0;
      beam      <= '0;
      misc_meta <= '0;
      misc      <= '0;
    end else begin
      sens_meta <= MUTING_SENSORS;
      sens      <= sens_meta;
      sens_prev <= sens;
      beam_meta <= BEAM_INTERRUPTED;
      beam      <= beam_meta;
      misc_meta <= {OVERRIDE_ACTIVE, AUXILIARY_DYNAMIC_INPUT};
      misc      <= misc_meta;
    end
  end

  wire override_on = misc[1];

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  muting_pkg::ctrl_t ctrl;
  logic [15:0]       delay_ms;
  logic [15:0]       hold_ms;
  logic [15:0]       total_s;
  logic              blank_remote;
  logic [7:0]        blank_cnt;
  logic              err_sticky;
  logic              err_event;
  logic [31:0]       status_word;

  wire bus_req   = AVS_READ | AVS_WRITE;
  wire bus_fire  = bus_req & ~AVS_WAITREQUEST;
  wire wr_fire   = AVS_WRITE & ~AVS_WAITREQUEST;
  wire wr_ctrl   = wr_fire && AVS_ADDRESS == muting_pkg::OFS_CTRL;
  wire wr_delay  = wr_fire && AVS_ADDRESS == muting_pkg::OFS_DELAY;
  wire wr_hold   = wr_fire && AVS_ADDRESS == muting_pkg::OFS_HOLD;
  wire wr_total  = wr_fire && AVS_ADDRESS == muting_pkg::OFS_TOTAL;
  wire wr_blank  = wr_fire && AVS_ADDRESS == muting_pkg::OFS_BLANK;
  wire wr_status = wr_fire && AVS_ADDRESS == muting_pkg::OFS_STATUS;
  wire err_clear = wr_status && AVS_WRITEDATA[muting_pkg::STATUS_ERR_BIT];

  muting_pkg::ctrl_t wr_ctrl_val;
  always_comb begin
    wr_ctrl_val = muting_pkg::ctrl_t'(AVS_WRITEDATA[15:0]);
    wr_ctrl_val.spare = '0;
    if (wr_ctrl_val.aux_dynamic_en) begin
      wr_ctrl_val.dir_en = 1'b1;
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    unique case (AVS_ADDRESS)
      muting_pkg::OFS_CTRL:   rd_mux = {16'h0000, ctrl};
      muting_pkg::OFS_DELAY:  rd_mux = {16'h0000, delay_ms};
      muting_pkg::OFS_HOLD:   rd_mux = {16'h0000, hold_ms};
      muting_pkg::OFS_TOTAL:  rd_mux = {16'h0000, total_s};
      muting_pkg::OFS_BLANK:  rd_mux = {16'h0000, blank_cnt, 7'h00, blank_remote};
      muting_pkg::OFS_STATUS: rd_mux = status_word;
      default:                rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST <= ~(bus_req & AVS_WAITREQUEST);
      if (bus_req & AVS_WAITREQUEST) begin
        AVS_READDATA <= AVS_READ ? rd_mux : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl         <= muting_pkg::ctrl_t'(muting_pkg::CTRL_RESET);
      delay_ms     <= 16'h0000;
      hold_ms      <= muting_pkg::HOLD_RESET;
      total_s      <= muting_pkg::TOTAL_RESET;
      blank_remote <= 1'b0;
      blank_cnt    <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wr_ctrl_val;
      end
      if (wr_delay) begin
        delay_ms <= clamp(AVS_WRITEDATA[15:0], 16'h0000, muting_pkg::END_DELAY_MAX_MS);
      end
      if (wr_hold) begin
        hold_ms <= AVS_WRITEDATA[15:0];
      end
      if (wr_total) begin
        total_s <= AVS_WRITEDATA[15:0];
      end
      if (wr_blank) begin
        blank_remote <= AVS_WRITEDATA[0];
        blank_cnt    <= AVS_WRITEDATA[muting_pkg::BLANK_CNT_LSB +: 8];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------------
  logic [31:0] pre_cnt;
  logic [9:0]  ms_in_s;
  wire ms_tick = pre_cnt == 32'(MS_CYCLES - 1);
  wire s_tick  = ms_tick && ms_in_s == 10'(muting_pkg::MS_PER_S - 1);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pre_cnt <= 32'h0000_0000;
      ms_in_s <= 10'h000;
    end else begin
      pre_cnt <= ms_tick ? 32'h0000_0000 : pre_cnt + 32'h0000_0001;
      if (ms_tick) begin
        ms_in_s <= s_tick ? 10'h000 : ms_in_s + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Muting condition and direction
  // ----------------------------------------------------------------------
  // pair needs both sensors
  wire pair_a     = sens[0] & sens[1];
  wire pair_b     = ctrl.four_sensors & sens[2] & sens[3];
  wire cond_valid = pair_a | pair_b;
  wire all_clear  = sens == 4'h0;
  wire dir_on     = ctrl.four_sensors & (ctrl.dir_en | ctrl.aux_dynamic_en);
  wire first_ok   = ctrl.dir_b_first ? pair_b & ~pair_a : pair_a & ~pair_b;
  wire start_ok   = dir_on ? first_ok : cond_valid;
  wire dir_fault  = dir_on & cond_valid & ~first_ok;

  // ----------------------------------------------------------------------
  // Sequence monitor
  // ----------------------------------------------------------------------
  logic [3:0] seq_step;
  logic       seq_rev;
  wire [3:0] rise    = sens & ~sens_prev;
  wire [3:0] fall    = ~sens & sens_prev;
  wire       seq_on  = ctrl.seq_en & ctrl.four_sensors;
  wire       any_edg = (rise | fall) != 4'h0;
  // changing direction picks order from first edge
  wire       pick_rv = ctrl.seq_changing ? rise[3] : ctrl.dir_b_first;
  wire       use_rev = seq_step == 4'h0 ? pick_rv : seq_rev;
  wire [1:0] exp_idx = seq_index(use_rev, seq_step[1:0]);
  wire [3:0] exp_bit = 4'h1 << exp_idx;
  wire       exp_hit = seq_step[2] ? fall == exp_bit && rise == 4'h0
                                   : rise == exp_bit && fall == 4'h0;
  wire       seq_bad = seq_on & ((any_edg & ~exp_hit) |
                                 (~any_edg & all_clear & seq_step != 4'h0));
  wire [3:0] next_seq_step = (seq_step == 4'h7) ? 4'h0 : seq_step + 4'h1;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      seq_step <= 4'h0;
      seq_rev  <= 1'b0;
    end else if (!seq_on || seq_bad) begin
      seq_step <= 4'h0;
      seq_rev  <= 1'b0;
    end else if (any_edg) begin
      seq_step <= next_seq_step;
      seq_rev  <= use_rev;
    end
  end

  // ----------------------------------------------------------------------
  // End of muting state machine
  // ----------------------------------------------------------------------
  muting_pkg::mute_state_t state;
  muting_pkg::mute_state_t next_state;
  logic [15:0] ms_cnt;
  logic [15:0] s_cnt;
  logic        path_was_hit;

  // Light path counts as interrupted when any beam is broken.
  wire path_clear  = beam == '0;
  wire path_ended  = ctrl.light_path_end_option & path_was_hit & path_clear;
  wire delay_zero  = delay_ms == 16'h0000;
  wire [15:0] total_lim = clamp(total_s, muting_pkg::TOTAL_MIN_S,
                                ctrl.exit_mon ? muting_pkg::TOTAL_MAX_EXIT_S
                                              : muting_pkg::TOTAL_MAX_S);
  // limit runs in every muted state
  wire total_out   = ctrl.total_en && s_cnt >= total_lim;
  wire hold_out    = ms_cnt >= hold_ms;
  wire delay_out   = ms_cnt >= delay_ms;
  wire muting_on   = state inside {muting_pkg::ST_MUTED, muting_pkg::ST_HOLD,
                                   muting_pkg::ST_DELAY};
  assign err_event = (muting_on & seq_bad) |
                     (state == muting_pkg::ST_IDLE & dir_fault);

  always_comb begin
    next_state = state;
    unique case (state)
      muting_pkg::ST_IDLE: begin
        if (dir_fault) begin
          next_state = muting_pkg::ST_CLEAR;
        end else if (start_ok) begin
          next_state = muting_pkg::ST_MUTED;
        end
      end
      muting_pkg::ST_MUTED: begin
        if (total_out || seq_bad) begin
          next_state = muting_pkg::ST_CLEAR;
        end else if (path_ended) begin
          next_state = delay_zero ? muting_pkg::ST_CLEAR : muting_pkg::ST_DELAY;
        end else if (!cond_valid && ctrl.exit_mon) begin
          next_state = muting_pkg::ST_HOLD;
        end else if (!cond_valid) begin
          next_state = muting_pkg::ST_CLEAR;
        end
      end
      muting_pkg::ST_HOLD: begin
        if (total_out || seq_bad || hold_out) begin
          next_state = muting_pkg::ST_CLEAR;
        end else if (path_ended) begin
          next_state = delay_zero ? muting_pkg::ST_CLEAR : muting_pkg::ST_DELAY;
        end
      end
      muting_pkg::ST_DELAY: begin
        if (total_out || seq_bad || delay_out) begin
          next_state = muting_pkg::ST_CLEAR;
        end else if (!cond_valid && !ctrl.exit_mon) begin
          next_state = muting_pkg::ST_CLEAR;
        end
      end
      muting_pkg::ST_CLEAR: begin
        if (all_clear) begin
          next_state = muting_pkg::ST_IDLE;
        end
      end
    endcase
  end

  wire restart_ms = next_state != state;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state        <= muting_pkg::ST_IDLE;
      ms_cnt       <= 16'h0000;
      s_cnt        <= 16'h0000;
      path_was_hit <= 1'b0;
    end else begin
      state <= next_state;
      if (restart_ms) begin
        ms_cnt <= 16'h0000;
      end else if (ms_tick && ms_cnt != 16'hFFFF) begin
        ms_cnt <= ms_cnt + 16'h0001;
      end
      if (!muting_on) begin
        s_cnt <= 16'h0000;
      end else if (s_tick && s_cnt != 16'hFFFF) begin
        s_cnt <= s_cnt + 16'h0001;
      end
      if (!muting_on) begin
        path_was_hit <= 1'b0;
      end else if (!path_clear) begin
        path_was_hit <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Beam evaluation and outputs
  // ----------------------------------------------------------------------
  // start side and count
  wire [BEAMS-1:0] part_mask = blank_mask(blank_remote, blank_cnt);
  wire [BEAMS-1:0] mute_mask = ctrl.partial_blank_en ? part_mask : '1;
  wire [BEAMS-1:0] eff_mask  = override_on ? '1 : muting_on ? mute_mask : '0;
  wire next_safety = (beam & ~eff_mask) == '0;
  wire next_lamp   = muting_on & ~ctrl.partial_blank_en;

  assign status_word = {16'h0000, 3'h0, state, seq_step, MUTING_ACTIVE,
                        SAFETY_SWITCH_OUTPUT, 1'b0, err_sticky};

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      err_sticky           <= 1'b0;
      SAFETY_SWITCH_OUTPUT <= 1'b0;
      MUTING_LAMP          <= 1'b0;
      MUTING_ACTIVE        <= 1'b0;
      MUTING_ERROR         <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle.
      err_sticky           <= err_event | (err_sticky & ~err_clear);
      SAFETY_SWITCH_OUTPUT <= next_safety;
      MUTING_LAMP          <= next_lamp;
      MUTING_ACTIVE        <= muting_on;
      MUTING_ERROR         <= err_sticky;
    end
  end

endmodule
`default_nettype wire

// ---- bench/muting_checker.sv ----
// Port-level assertions for the muting supervisor.
`timescale 1ns/1ps
`default_nettype none
module muting_checker #(
  parameter int BEAMS     = 16,
  parameter int MS_CYCLES = 4
) (
  input wire logic                 CORE_CLK,
  input wire logic                 RST,
  input wire logic [7:0]           AVS_ADDRESS,
  input wire logic                 AVS_READ,
  input wire logic                 AVS_WRITE,
  input wire logic [31:0]          AVS_WRITEDATA,
  input wire logic [31:0]          AVS_READDATA,
  input wire logic                 AVS_WAITREQUEST,
  input wire muting_pkg::sensors_t MUTING_SENSORS,
  input wire logic                 AUXILIARY_DYNAMIC_INPUT,
  input wire logic                 OVERRIDE_ACTIVE,
  input wire logic [BEAMS-1:0]     BEAM_INTERRUPTED,
  input wire logic                 SAFETY_SWITCH_OUTPUT,
  input wire logic                 MUTING_LAMP,
  input wire logic                 MUTING_ACTIVE,
  input wire logic                 MUTING_ERROR
);
  logic [3:0] since_pair;
  logic [1:0] clr_cnt;
  wire logic  pair_ok = (MUTING_SENSORS[0] & MUTING_SENSORS[1]) |
                        (MUTING_SENSORS[2] & MUTING_SENSORS[3]);
  wire logic  clr_req = AVS_WRITE & !AVS_WAITREQUEST & (AVS_ADDRESS == 8'h14) &
                        AVS_WRITEDATA[0];
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // Age of the last full sensor pair, and a short window after an error clear.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      since_pair <= 4'hF;
      clr_cnt    <= 2'h0;
    end else begin
      since_pair <= pair_ok ? 4'h0 : (since_pair == 4'hF ? since_pair : since_pair + 4'h1);
      clr_cnt    <= clr_req ? 2'h3 : (clr_cnt == 2'h0 ? clr_cnt : clr_cnt - 2'h1);
    end
  end
  AST_WAIT_PULSE: assert property ($fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  AST_WAIT_ANSWER: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus request not answered after one wait cycle");
  AST_IDLE_WAIT: assert property (!(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST)
    else $error("waitrequest low without a request");
  AST_UNMAPPED: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > 8'h14 |->
    AVS_READDATA == 32'h0000_0000) else $error("unmapped read returned data");
  AST_LAMP_MUTED: assert property (MUTING_LAMP |-> MUTING_ACTIVE)
    else $error("lamp lit outside muting");
  AST_SAFE_OFF: assert property (((|BEAM_INTERRUPTED) && !OVERRIDE_ACTIVE && !MUTING_ACTIVE) [*6]
    |-> !SAFETY_SWITCH_OUTPUT) else $error("safety output on with beam interrupted");
  AST_SAFE_ON: assert property ((BEAM_INTERRUPTED == '0) [*6] |-> SAFETY_SWITCH_OUTPUT)
    else $error("safety output off with clear light path");
  AST_START_PAIR: assert property ($rose(MUTING_ACTIVE) |-> since_pair < 4'h8)
    else $error("muting began without a full sensor pair");
  AST_ERR_CLEAR: assert property ($fell(MUTING_ERROR) |-> clr_cnt != 2'h0)
    else $error("error flag dropped without a clear write");
  COV_MUTE: cover property ($rose(MUTING_ACTIVE));
  COV_ERR: cover property ($rose(MUTING_ERROR));
  COV_BLANK: cover property (MUTING_ACTIVE && !MUTING_LAMP && (|BEAM_INTERRUPTED));
endmodule
bind muting_end_sequence_blanking muting_checker #(.BEAMS(BEAMS), .MS_CYCLES(MS_CYCLES))
  i_muting_checker (.CORE_CLK(CORE_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .MUTING_SENSORS(MUTING_SENSORS), .AUXILIARY_DYNAMIC_INPUT(AUXILIARY_DYNAMIC_INPUT),
  .OVERRIDE_ACTIVE(OVERRIDE_ACTIVE), .BEAM_INTERRUPTED(BEAM_INTERRUPTED),
  .SAFETY_SWITCH_OUTPUT(SAFETY_SWITCH_OUTPUT), .MUTING_LAMP(MUTING_LAMP),
  .MUTING_ACTIVE(MUTING_ACTIVE), .MUTING_ERROR(MUTING_ERROR));
`default_nettype wire

// ---- bench/sensor_field.sv ----
// Behavioural muting sensors and light path in front of the supervisor.
`timescale 1ns/1ps
`default_nettype none
module sensor_field #(
  parameter int BEAMS = 16
) (
  input  wire logic                 clk,
  output var  muting_pkg::sensors_t sens,
  output var  logic [BEAMS-1:0]     beams
);
  initial begin
    sens  = '0;
    beams = '0;
  end
  // Levels change just after an edge and then hold for n cycles, like real scans.
  task automatic put(input logic [3:0] s, input logic [BEAMS-1:0] b, input int n);
    @(posedge clk);
    sens  <= muting_pkg::sensors_t'(s);
    beams <= b;
    repeat (n) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench of the muting supervisor with random and corner stimulus.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                 clk, rst, rd, wr, wait_req, aux, ovr, safe, lamp, act, err;
  logic [7:0]           adr;
  logic [31:0]          wdata, rdata, q;
  logic [15:0]          beams, bi, bo;
  logic [47:0]          tbl [6];
  muting_pkg::sensors_t sens;
  int                   err_total, cmp_count, cyc, seed, r;

  muting_end_sequence_blanking #(.BEAMS(16), .MS_CYCLES(4)) i_muting_end_sequence_blanking (
    .CORE_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
    .MUTING_SENSORS(sens), .AUXILIARY_DYNAMIC_INPUT(aux), .OVERRIDE_ACTIVE(ovr),
    .BEAM_INTERRUPTED(beams), .SAFETY_SWITCH_OUTPUT(safe), .MUTING_LAMP(lamp),
    .MUTING_ACTIVE(act), .MUTING_ERROR(err));
  sensor_field #(.BEAMS(16)) i_sensor_field (.clk(clk), .sens(sens), .beams(beams));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] clampd(input logic [31:0] d);
    return (d > 32'h0000_03E8) ? 32'h0000_03E8 : d;
  endfunction

  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr   <= a;
    wr    <= w;
    rd    <= !w;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk(q, e);
  endtask

  task drive(input logic [3:0] s, input logic [15:0] b, input int n);
    i_sensor_field.put(s, b, n);
  endtask

  task done(input string s);
    $display("%0s finished at %0t", s, $time);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 50000) begin
      err_total++;
      results();
    end
  end

  initial begin
    seed = 19487;
    {rst, rd, wr, aux, ovr} = 5'h10;
    adr = 8'h00;
    wdata = '0;
    {err_total, cmp_count, cyc} = '0;
    tbl = '{48'h0058_137F_EC80, 48'h0078_8CEF_7310, 48'h1078_137F_EC80,
            48'h00C8_8CEF_7310, 48'h00C8_137F_EC80, 48'h1058_1373_1000};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h08, 32'h0000_01F4);
    rdc(8'h0C, 32'h0000_003C);
    rdc(8'h20, 32'h0000_0000);
    bus(1'b1, 8'h04, 32'h0000_FFFF);
    rdc(8'h04, clampd(32'h0000_FFFF));
    bus(1'b1, 8'h00, 32'h0000_0100);
    rdc(8'h00, 32'h0000_0110);
    bus(1'b1, 8'h00, 32'h0000_0000);
    done("registers");
    drive(4'h1, 16'h0001, 8);
    chk(act, 1'b0);
    drive(4'h3, 16'h0001, 8);
    chk({lamp, safe, act}, 3'h7);
    drive(4'h2, 16'h0001, 8);
    chk({safe, act}, 2'h0);
    drive(4'h0, 16'h0000, 8);
    bus(1'b1, 8'h04, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0001);
    drive(4'h3, 16'h0001, 8);
    drive(4'h3, 16'h0000, 8);
    chk(act, 1'b0);
    drive(4'h0, 16'h0000, 8);
    drive(4'h3, 16'h0001, 8);
    drive(4'h0, 16'h0001, 8);
    chk(act, 1'b0);
    drive(4'h0, 16'h0000, 8);
    bus(1'b1, 8'h04, 32'h0000_0003);
    drive(4'h3, 16'h0001, 8);
    drive(4'h3, 16'h0000, 6);
    chk(act, 1'b1);
    drive(4'h3, 16'h0000, 16);
    chk(act, 1'b0);
    drive(4'h0, 16'h0000, 8);
    done("end of muting");
    // Hold stays short and exit monitoring is paired with the total limit.
    bus(1'b1, 8'h08, 32'h0000_0002);
    bus(1'b1, 8'h00, 32'h0000_0006);
    drive(4'h3, 16'h0001, 8);
    drive(4'h0, 16'h0001, 4);
    chk(act, 1'b1);
    drive(4'h0, 16'h0001, 12);
    chk(act, 1'b0);
    drive(4'h0, 16'h0000, 8);
    done("exit hold");
    bus(1'b1, 8'h00, 32'h0000_0018);
    drive(4'hC, 16'h0001, 8);
    chk(err, 1'b1);
    rdc(8'h14, 32'h0000_1001);
    drive(4'h0, 16'h0000, 4);
    bus(1'b1, 8'h14, 32'h0000_0001);
    drive(4'h0, 16'h0000, 4);
    r = $random(seed) & 1;
    drive(r ? 4'h2 : 4'h1, 16'h0001, 4);
    drive(4'h3, 16'h0001, 8);
    chk(act, 1'b1);
    drive(4'hF, 16'h0001, 8);
    drive(4'hC, 16'h0001, 8);
    drive(4'h0, 16'h0001, 8);
    chk({err, act}, 2'h0);
    drive(4'h0, 16'h0000, 8);
    done("direction");
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 8'h00, {20'h0_0000, tbl[i][43:32]});
      for (int k = 7; k >= 0; k--) begin
        drive(tbl[i][k*4 +: 4], 16'h0001, 4);
      end
      chk(err, tbl[i][44]);
      bus(1'b1, 8'h14, 32'h0000_0001);
      drive(4'h0, 16'h0000, 4);
    end
    done("sequence");
    bus(1'b1, 8'h00, 32'h0000_0204);
    bus(1'b1, 8'h0C, 32'h0000_000A);
    for (int side = 0; side < 2; side++) begin
      r = $random(seed) & 3;
      bi = 16'h0001 << (side ? 12 + r : r);
      bo = 16'h0001 << (side ? r : 12 + r);
      bus(1'b1, 8'h10, {16'h0000, 8'h04, 7'h00, 1'(side)});
      drive(4'h3, bi, 8);
      chk({lamp, safe, act}, 3'h3);
      drive(4'h3, bi | bo, 8);
      chk(safe, 1'b0);
      ovr <= 1'b1;
      drive(4'h3, bi | bo, 8);
      chk(safe, 1'b1);
      ovr <= 1'b0;
      drive(4'h0, 16'h0000, 8);
    end
    drive(4'h3, bi, 30000);
    chk(act, 1'b1);
    drive(4'h3, bi, 12000);
    chk(act, 1'b0);
    drive(4'h0, 16'h0000, 8);
    done("partial blanking");
    results();
  end
endmodule
`default_nettype wire
